// >>> src/sfic_cmd.sv
// serial flash id, signature, power and continuous read reset commands
// ----------------------------------------------------------------------
// Notes on behaviour
// R1: id read: opcode, two dummies, order byte
// R2: order byte 01h sends device code first
// R3: id read returns maker and device bytes
// R4: id read not decoded during program/erase
// R5: chip select rise ends id read, standby
// R6: deep sleep ignores all but release
// R7: release: opcode, three dummies, signature out
// R8: signature returned even when awake
// R9: release not decoded during busy cycles
// R10: signature repeats while clocks continue
// R11: rise after signature: long wake delay
// R12: rise before signature: short wake delay
// R13: precharge mode: opcode plus three dummies
// R14: release, write enable, sleep leave precharge
// R15: all-ones reset sets low mode flag
// R16: quad mode reset needs eight ones
// R17: dual mode reset needs sixteen ones
// R18: power-on clears both mode flags
// R19: host resets continuous mode before commands
// R20: sleep only if deselected after eighth bit
// R21: unknown or blocked opcode ignored till deselect
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`include "sfic_regs.svh"
module sfic_cmd import sfic_pkg::*; #(
  parameter logic [7:0] IDREAD_OPCODE = `SFIC_OP_IDREAD_DEFAULT,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'ha5 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic serial_in_line,
  output logic so_out,
  output logic so_oe,
  // array status
  input wire logic busy_prog_erase,
  input wire logic busy_status_write,
  // continuous read mode from the fast read logic
  input wire logic mode_load,
  input wire logic [1:0] mode_value,
  input wire logic io_mode_dual,
  // state
  output logic continuous_read_flag_hi,
  output logic continuous_read_flag_lo,
  output logic high_perf_precharge_mode,
  output logic deep_sleep,
  output logic wake_pending,
  output logic standby
);

  // --------------------------------------------------------------------
  // pin synchronisers and edge detection
  // --------------------------------------------------------------------
  logic cs_n_s, sck_s, din_s;
  logic cs_n_d, sck_d;
  logic cs_rise, cs_fall, sck_rise, sck_fall, bit_rise;

  sfic_sync #(.W(3)) u_sync (
    .clk(clk),
    .srst(srst),
    .pin_in({cs_n_pin, sck_pin, serial_in_line}),
    .sync_out({cs_n_s, sck_s, din_s})
  );

  // delayed copies reset to the synchroniser's reset level: no false edge
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      cs_n_d <= cs_n_s;
      sck_d <= sck_s;
    end
  end

  assign cs_rise = cs_n_s & ~cs_n_d;
  assign cs_fall = ~cs_n_s & cs_n_d;
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  // bits count only inside a frame that was already open
  assign bit_rise = sck_rise & ~cs_n_s & ~cs_n_d;

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  sfic_state_e state_reg, dec_state;
  sfic_cmd_e cmd_reg, dec_cmd;
  sfic_pwr_e pwr_reg;
  logic [4:0] cnt_reg;
  logic [7:0] op_sh_reg;
  logic [7:0] op_next;
  logic opcode_done, dummy_done, addr_done, crst_done;
  logic [4:0] dummy_last, crst_last;
  logic busy_any, in_deep, cont_active;
  logic [15:0] id_pair;

  assign op_next = {op_sh_reg[6:0], din_s};
  assign busy_any = busy_prog_erase | busy_status_write;
  assign in_deep = (pwr_reg == PWR_DEEP) | (pwr_reg == PWR_ENTERING);
  assign cont_active = ({continuous_read_flag_hi, continuous_read_flag_lo} == `SFIC_MODE_CONT);
  assign opcode_done = bit_rise & (state_reg == ST_OPCODE) & (cnt_reg == `SFIC_OP_LAST);
  assign dummy_last = (cmd_reg == CMD_IDREAD) ? `SFIC_IDREAD_DUMMY_LAST :
                      (cmd_reg == CMD_WAKE) ? `SFIC_WAKE_DUMMY_LAST : `SFIC_PRECHG_DUMMY_LAST;
  assign dummy_done = bit_rise & (state_reg == ST_DUMMY) & (cnt_reg == dummy_last);
  assign addr_done = bit_rise & (state_reg == ST_ADDR) & (cnt_reg == `SFIC_ADDR_LAST);
  assign crst_last = io_mode_dual ? `SFIC_CRST_DUAL_LAST : `SFIC_CRST_QUAD_LAST; // [R16] [R17]
  assign crst_done = bit_rise & (state_reg == ST_CRST) & din_s & (cnt_reg == crst_last);
  // order byte 01h puts the device code first, anything else the maker code
  assign id_pair = (op_next == `SFIC_ORDER_DEV_FIRST) ? {PART_CODE, MAKER_CODE} :
                   {MAKER_CODE, PART_CODE}; // [R2] [R3]

  always_comb begin
    dec_state = ST_IGNORE; // [R21]
    dec_cmd = CMD_NONE;
    if (in_deep) begin
      if (op_next == `SFIC_OP_WAKE && !busy_any) begin // [R6]
        dec_state = ST_DUMMY;
        dec_cmd = CMD_WAKE;
      end
    end else if (op_next == `SFIC_OP_WAKE) begin
      if (!busy_any) begin // [R9] [R8]
        dec_state = ST_DUMMY;
        dec_cmd = CMD_WAKE;
      end
    end else if (op_next == IDREAD_OPCODE) begin
      if (!busy_prog_erase) begin // [R4]
        dec_state = ST_DUMMY;
        dec_cmd = CMD_IDREAD;
      end
    end else if (op_next == `SFIC_OP_PRECHG) begin
      dec_state = ST_DUMMY; // [R13]
      dec_cmd = CMD_PRECHG;
    end else if (op_next == `SFIC_OP_DEEP) begin
      if (!busy_any) begin
        dec_state = ST_HOLD;
        dec_cmd = CMD_DEEP;
      end
    end
  end

  // --------------------------------------------------------------------
  // frame sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= CMD_NONE;
      cnt_reg <= 5'h00;
      op_sh_reg <= 8'h00;
    end else if (cs_rise) begin
      state_reg <= ST_IDLE; // [R5] [R21]
    end else if (cs_fall) begin
      // an open continuous read frame is checked only for the all-ones reset, then ignored
      state_reg <= cont_active ? ST_CRST : ST_OPCODE;
      cmd_reg <= CMD_NONE;
      cnt_reg <= 5'h00;
      op_sh_reg <= 8'h00;
    end else if (bit_rise) begin
      case (state_reg)
        ST_OPCODE: begin
          op_sh_reg <= op_next;
          cnt_reg <= cnt_reg + 5'h01;
          if (opcode_done) begin
            state_reg <= dec_state;
            cmd_reg <= dec_cmd;
            cnt_reg <= 5'h00;
          end
        end
        ST_DUMMY: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (dummy_done) begin // [R1] [R7]
            cnt_reg <= 5'h00;
            case (cmd_reg)
              CMD_IDREAD: state_reg <= ST_ADDR;
              CMD_WAKE: state_reg <= ST_DATA;
              default: state_reg <= ST_HOLD;
            endcase
          end
        end
        ST_ADDR: begin
          op_sh_reg <= op_next;
          cnt_reg <= cnt_reg + 5'h01;
          if (addr_done) begin
            state_reg <= ST_DATA;
          end
        end
        ST_CRST: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (!din_s || crst_done) begin
            state_reg <= ST_IGNORE;
          end
        end
        ST_HOLD: begin
          // a power-down frame clocked past its eighth bit is void
          if (cmd_reg == CMD_DEEP) begin
            state_reg <= ST_IGNORE; // [R20]
          end
        end
        default: state_reg <= state_reg;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // output shifter
  // --------------------------------------------------------------------
  logic [15:0] out_sh_reg;
  logic [3:0] out_cnt_reg;
  logic sig_done_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      out_sh_reg <= 16'h0000;
      out_cnt_reg <= 4'h0;
      sig_done_reg <= 1'b0;
      so_out <= 1'b0;
    end else if (cs_fall) begin
      out_cnt_reg <= 4'h0;
      sig_done_reg <= 1'b0;
    end else if (addr_done) begin
      out_sh_reg <= id_pair; // [R2]
    end else if (dummy_done && cmd_reg == CMD_WAKE) begin
      // two copies in a rotating register repeat the signature for free
      out_sh_reg <= {PART_CODE, PART_CODE}; // [R10]
    end else if (sck_fall && state_reg == ST_DATA && !cs_n_s) begin
      so_out <= out_sh_reg[15]; // [R3] [R7]
      out_sh_reg <= {out_sh_reg[14:0], out_sh_reg[15]}; // [R10]
      if (out_cnt_reg != `SFIC_SIG_BITS) begin
        out_cnt_reg <= out_cnt_reg + 4'h1;
      end
      if (out_cnt_reg == `SFIC_SIG_BITS - 4'h1 && cmd_reg == CMD_WAKE) begin
        sig_done_reg <= 1'b1;
      end
    end
  end

  assign so_oe = (state_reg == ST_DATA) & ~cs_n_s;

  // --------------------------------------------------------------------
  // power state and wake timer
  // --------------------------------------------------------------------
  logic tmr_load, tmr_busy, tmr_done;
  logic [`SFIC_TMR_W-1:0] tmr_val;
  logic sleep_fire, wake_fire;

  assign sleep_fire = cs_rise & (state_reg == ST_HOLD) & (cmd_reg == CMD_DEEP); // [R20]
  assign wake_fire = cs_rise & (cmd_reg == CMD_WAKE) & (pwr_reg == PWR_DEEP);

  always_comb begin
    tmr_load = 1'b0;
    tmr_val = `SFIC_TMR_W'(`SFIC_T_SLEEP_CYC);
    if (sleep_fire && pwr_reg == PWR_ON) begin
      tmr_load = 1'b1;
    end else if (wake_fire) begin
      tmr_load = 1'b1;
      tmr_val = sig_done_reg ? `SFIC_TMR_W'(`SFIC_T_WAKE2_CYC) :
                `SFIC_TMR_W'(`SFIC_T_WAKE1_CYC); // [R11] [R12]
    end
  end

  sfic_wake_timer #(.W(`SFIC_TMR_W)) u_timer (
    .clk(clk),
    .srst(srst),
    .load(tmr_load),
    .load_val(tmr_val),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_reg <= PWR_ON;
    end else begin
      case (pwr_reg)
        PWR_ON: if (sleep_fire) pwr_reg <= PWR_ENTERING;
        PWR_ENTERING: if (tmr_done) pwr_reg <= PWR_DEEP;
        PWR_DEEP: if (wake_fire) pwr_reg <= PWR_WAKING; // [R6]
        PWR_WAKING: if (tmr_done) pwr_reg <= PWR_ON;
        default: pwr_reg <= PWR_ON;
      endcase
    end
  end

  assign deep_sleep = in_deep;
  assign wake_pending = (pwr_reg == PWR_WAKING);
  assign standby = (state_reg == ST_IDLE) & (pwr_reg == PWR_ON);

  // --------------------------------------------------------------------
  // precharge mode
  // --------------------------------------------------------------------
  logic prechg_leave;

  assign prechg_leave = opcode_done & ~in_deep & ((op_next == `SFIC_OP_WAKE) |
                     (op_next == `SFIC_OP_WREN) | (op_next == `SFIC_OP_DEEP));

  always_ff @(posedge clk) begin
    if (srst) begin
      high_perf_precharge_mode <= 1'b0;
    end else if (prechg_leave) begin
      high_perf_precharge_mode <= 1'b0; // [R14]
    end else if (dummy_done && cmd_reg == CMD_PRECHG) begin
      high_perf_precharge_mode <= 1'b1; // [R13]
    end
  end

  // --------------------------------------------------------------------
  // continuous read mode flags
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      {continuous_read_flag_hi, continuous_read_flag_lo} <= `SFIC_MODE_RESET; // [R18]
    end else if (crst_done) begin
      // the reset wins over a load from the read logic in the same cycle
      continuous_read_flag_lo <= 1'b1; // [R15]
    end else if (mode_load) begin
      {continuous_read_flag_hi, continuous_read_flag_lo} <= mode_value;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  idread_busy_block_a: assert property (@(posedge clk) disable iff (srst) // [R4]
    (opcode_done && !in_deep && op_next == IDREAD_OPCODE && busy_prog_erase)
      |=> state_reg == ST_IGNORE)
    else $error("id read decoded during program or erase");

  wake_busy_block_a: assert property (@(posedge clk) disable iff (srst) // [R9]
    (opcode_done && op_next == `SFIC_OP_WAKE && busy_status_write)
      |=> state_reg == ST_IGNORE && cmd_reg == CMD_NONE)
    else $error("release decoded during a busy cycle");

  deep_ignore_a: assert property (@(posedge clk) disable iff (srst) // [R6]
    (opcode_done && pwr_reg == PWR_DEEP && op_next != `SFIC_OP_WAKE)
      |=> state_reg == ST_IGNORE ##1 pwr_reg == PWR_DEEP)
    else $error("instruction accepted in deep sleep");

  id_order_a: assert property (@(posedge clk) disable iff (srst) // [R2]
    addr_done |=> state_reg == ST_DATA && out_sh_reg ==
      (($past(op_next) == `SFIC_ORDER_DEV_FIRST) ? {PART_CODE, MAKER_CODE}
                                                 : {MAKER_CODE, PART_CODE}))
    else $error("identification byte order wrong");

  deselect_idle_a: assert property (@(posedge clk) disable iff (srst) // [R5]
    cs_rise |=> state_reg == ST_IDLE && !so_oe)
    else $error("frame not closed on deselect");

  sleep_entry_a: assert property (@(posedge clk) disable iff (srst) // [R20]
    (sleep_fire && pwr_reg == PWR_ON) |=> pwr_reg == PWR_ENTERING && tmr_busy)
    else $error("power-down not started on deselect");

  wake_delay_a: assert property (@(posedge clk) disable iff (srst) // [R11]
    (wake_fire && sig_done_reg) |=> pwr_reg == PWR_WAKING &&
      $past(tmr_val) == `SFIC_TMR_W'(`SFIC_T_WAKE2_CYC))
    else $error("long wake delay not used");

  precharge_leave_a: assert property (@(posedge clk) disable iff (srst) // [R14]
    (high_perf_precharge_mode && opcode_done && !in_deep &&
     op_next == `SFIC_OP_WREN) |=> !high_perf_precharge_mode)
    else $error("precharge mode kept after write enable");

  mode_clear_a: assert property (@(posedge clk) // [R18]
    srst |=> !continuous_read_flag_hi && !continuous_read_flag_lo)
    else $error("mode flags not cleared at reset");

  crst_set_a: assert property (@(posedge clk) disable iff (srst) // [R15]
    crst_done |=> continuous_read_flag_lo && state_reg == ST_IGNORE)
    else $error("continuous read reset not taken");

endmodule : sfic_cmd

// >>> src/sfic_regs.svh
// constants for the serial flash identification and power command block
`ifndef SFIC_REGS_SVH
`define SFIC_REGS_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define SFIC_OP_WAKE 8'hab
`define SFIC_OP_PRECHG 8'ha3
`define SFIC_OP_WREN 8'h06
`define SFIC_OP_DEEP 8'hb9
`define SFIC_OP_IDREAD_DEFAULT 8'h90
`define SFIC_ORDER_DEV_FIRST 8'h01

// ----------------------------------------------------------------------
// bit counts within a frame
// ----------------------------------------------------------------------
`define SFIC_OP_LAST 5'h07
`define SFIC_ADDR_LAST 5'h07
`define SFIC_IDREAD_DUMMY_LAST 5'h0f
`define SFIC_WAKE_DUMMY_LAST 5'h17
`define SFIC_PRECHG_DUMMY_LAST 5'h17
`define SFIC_CRST_QUAD_LAST 5'h07
`define SFIC_CRST_DUAL_LAST 5'h0f
`define SFIC_SIG_BITS 4'h8

// ----------------------------------------------------------------------
// mode flag values: reset and continuous read
// ----------------------------------------------------------------------
`define SFIC_MODE_RESET 2'h0
`define SFIC_MODE_CONT 2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SFIC_CLK_MHZ 125
`define SFIC_T_SLEEP_NS 3000
// the short wake delay is kept below the long one
`define SFIC_T_WAKE1_NS 1800
`define SFIC_T_WAKE2_NS 3000
`define SFIC_T_SLEEP_CYC (((`SFIC_T_SLEEP_NS * `SFIC_CLK_MHZ) + 999) / 1000)
`define SFIC_T_WAKE1_CYC (((`SFIC_T_WAKE1_NS * `SFIC_CLK_MHZ) + 999) / 1000)
`define SFIC_T_WAKE2_CYC (((`SFIC_T_WAKE2_NS * `SFIC_CLK_MHZ) + 999) / 1000)
`define SFIC_TMR_W 12

`endif

// >>> src/sfic_pkg.sv
// types shared by the serial flash command block
package sfic_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_DUMMY, ST_ADDR, ST_DATA, ST_HOLD, ST_CRST, ST_IGNORE
  } sfic_state_e;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_IDREAD, CMD_WAKE, CMD_PRECHG, CMD_DEEP
  } sfic_cmd_e;

  typedef enum logic [1:0] {
    PWR_ON, PWR_ENTERING, PWR_DEEP, PWR_WAKING
  } sfic_pwr_e;

endpackage : sfic_pkg

// >>> src/sfic_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sfic_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pins and synchronised copies
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end

endmodule : sfic_sync

// >>> src/sfic_wake_timer.sv
// down counter for power state transition delays
`timescale 1ns/100ps
module sfic_wake_timer #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // load and status
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
      done <= 1'b0;
    end else if (load) begin
      cnt_reg <= load_val;
      done <= 1'b0;
    end else begin
      done <= (cnt_reg == W'(1));
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - W'(1);
      end
    end
  end

  assign busy = (cnt_reg != '0);

endmodule : sfic_wake_timer

// >>> verification/sfic_host_model.sv
// spi host model that drives the serial pins of the command block
`timescale 1ns/100ps
module sfic_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_n_pin,
  output logic sck_pin,
  output logic serial_in_line,
  input wire logic so_out,
  input wire logic so_oe
);
  logic oe_seen;

  initial begin
    cs_n_pin = 1'b1;
    sck_pin = 1'b0;
    serial_in_line = 1'b0;
    oe_seen = 1'b0;
  end

  // pins move only on falling clk edges; enable is watched on every cycle
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      if (so_oe === 1'b1) oe_seen = 1'b1;
    end
  endtask : tick

  // ----------------------------------------------------------------------
  // one frame: sck idles low, half period 5 clk, tx sent msb first
  // ----------------------------------------------------------------------
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx, input int gap,
                       output logic [31:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    tick(1);
    cs_n_pin = 1'b0;
    tick(4);
    for (int i = ntx - 1; i >= 0; i--) begin
      serial_in_line = tx[i];
      tick(5);
      sck_pin = 1'b1;
      tick(5);
      sck_pin = 1'b0;
    end
    // line no longer driven by intent: show the inverse, not a held value
    serial_in_line = ~serial_in_line;
    for (int i = 0; i < nrx; i++) begin
      tick(5);
      rx = {rx[30:0], so_out};
      sck_pin = 1'b1;
      tick(5);
      sck_pin = 1'b0;
    end
    tick(5);
    // no rising sck after the last bit, so a power-down frame stays valid
    cs_n_pin = 1'b1;
    tick(gap);
  endtask : frame
endmodule : sfic_host_model

// >>> verification/tb_top.sv
// self-checking bench for the serial flash command block
`timescale 1ns/100ps
`include "sfic_regs.svh"
module tb_top;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  localparam logic [7:0] PART = 8'hc3; // arbitrary value
  localparam logic [7:0] IDREAD = `SFIC_OP_IDREAD_DEFAULT;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic busy_prog_erase = 1'b0;
  logic busy_status_write = 1'b0;
  logic mode_load = 1'b0;
  logic [1:0] mode_value = 2'h0;
  logic io_mode_dual = 1'b0;
  logic cs_n_pin, sck_pin, serial_in_line, so_out, so_oe;
  logic continuous_read_flag_hi, continuous_read_flag_lo, high_perf_precharge_mode;
  logic deep_sleep, wake_pending, standby;
  int failures = 0;
  int check_count = 0;

  always #4 clk = ~clk;

  sfic_host_model host (.clk(clk), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .serial_in_line(serial_in_line), .so_out(so_out), .so_oe(so_oe));

  sfic_cmd #(.MAKER_CODE(MAKER), .PART_CODE(PART)) uut (.clk(clk), .srst(srst),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .serial_in_line(serial_in_line),
    .so_out(so_out), .so_oe(so_oe), .busy_prog_erase(busy_prog_erase),
    .busy_status_write(busy_status_write), .mode_load(mode_load), .mode_value(mode_value),
    .io_mode_dual(io_mode_dual), .continuous_read_flag_hi(continuous_read_flag_hi),
    .continuous_read_flag_lo(continuous_read_flag_lo),
    .high_perf_precharge_mode(high_perf_precharge_mode), .deep_sleep(deep_sleep),
    .wake_pending(wake_pending), .standby(standby));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic wrap_up;
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // cycles of wake delay, bounded so a stuck flag cannot hang the run
  task automatic wake_len(output int n);
    int i;
    n = 0;
    i = 0;
    while (wake_pending !== 1'b1 && i < 10) begin
      wait_clk(1);
      i++;
    end
    while (wake_pending === 1'b1 && n < 1000) begin
      wait_clk(1);
      n++;
    end
  endtask : wake_len

  task automatic sleep;
    logic [31:0] rx;
    host.frame({24'h0, `SFIC_OP_DEEP}, 8, 0, 8, rx);
    wait_clk(`SFIC_T_SLEEP_CYC + 20);
    chk(32'(deep_sleep), 32'h1, "power-down entry");
  endtask : sleep

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk(32'({continuous_read_flag_hi, continuous_read_flag_lo, high_perf_precharge_mode,
      deep_sleep, wake_pending, standby, so_oe}), 32'h2, "reset state");
  endtask : t_reset

  task automatic t_idread;
    logic [31:0] rx;
    host.frame({IDREAD, 16'h0000, 8'h00}, 32, 16, 8, rx);
    chk(rx, {16'h0, MAKER, PART}, "id order 00");
    host.frame({IDREAD, 16'hffff, 8'h01}, 32, 16, 8, rx);
    chk(rx, {16'h0, PART, MAKER}, "id order 01");
    host.frame({IDREAD, 24'h0}, 32, 4, 8, rx);
    chk(rx, {28'h0, MAKER[7:4]}, "id cut short");
    chk(32'({standby, so_oe}), 32'h2, "standby after cut");
  endtask : t_idread

  task automatic t_busy;
    logic [31:0] rx;
    busy_prog_erase = 1'b1;
    host.frame({IDREAD, 24'h0}, 32, 16, 8, rx);
    chk(32'(host.oe_seen), 32'h0, "id read while erasing");
    busy_prog_erase = 1'b0;
    busy_status_write = 1'b1;
    host.frame({`SFIC_OP_WAKE, 24'h0}, 32, 8, 8, rx);
    chk(32'(host.oe_seen), 32'h0, "release while status write");
    host.frame({IDREAD, 24'h0}, 32, 16, 8, rx);
    chk(rx, {16'h0, MAKER, PART}, "id read while status write");
    busy_status_write = 1'b0;
    host.frame({24'h0, 8'h3c}, 8, 16, 8, rx);
    chk(32'({host.oe_seen, standby}), 32'h1, "unknown opcode");
  endtask : t_busy

  task automatic t_wake_awake;
    logic [31:0] rx;
    host.frame({`SFIC_OP_WAKE, 24'h0}, 32, 16, 8, rx);
    chk(rx, {16'h0, PART, PART}, "signature repeated");
    chk(32'({deep_sleep, wake_pending, standby}), 32'h1, "awake release");
  endtask : t_wake_awake

  task automatic t_deep;
    logic [31:0] rx;
    int n;
    host.frame({23'h0, `SFIC_OP_DEEP, 1'b0}, 9, 0, 8, rx);
    wait_clk(20);
    chk(32'(deep_sleep), 32'h0, "power-down with extra bit");
    sleep();
    host.frame({IDREAD, 24'h0}, 32, 16, 8, rx);
    chk(32'({host.oe_seen, deep_sleep}), 32'h1, "id read while deep");
    host.frame({`SFIC_OP_WAKE, 24'h0}, 32, 8, 0, rx);
    chk(rx, {24'h0, PART}, "signature from deep");
    wake_len(n);
    chk(32'(n >= `SFIC_T_WAKE2_CYC && n <= `SFIC_T_WAKE2_CYC + 3), 32'h1, "long wake");
    chk(32'({deep_sleep, standby}), 32'h1, "awake after long wake");
    sleep();
    host.frame({24'h0, `SFIC_OP_WAKE}, 8, 0, 0, rx);
    wake_len(n);
    chk(32'(n >= `SFIC_T_WAKE1_CYC && n <= `SFIC_T_WAKE1_CYC + 3), 32'h1, "short wake");
    chk(32'({deep_sleep, standby}), 32'h1, "awake after short wake");
  endtask : t_deep

  task automatic t_prechg;
    logic [31:0] rx;
    int n;
    logic [7:0] ends [3] = '{`SFIC_OP_WREN, `SFIC_OP_DEEP, `SFIC_OP_WAKE};
    foreach (ends[k]) begin
      host.frame({`SFIC_OP_PRECHG, 24'h0}, 32, 0, 8, rx);
      chk(32'(high_perf_precharge_mode), 32'h1, "precharge on");
      host.frame({24'h0, ends[k]}, 8, 0, 8, rx);
      chk(32'(high_perf_precharge_mode), 32'h0, "precharge off");
      if (deep_sleep === 1'b1) begin
        wait_clk(`SFIC_T_SLEEP_CYC + 20);
        host.frame({24'h0, `SFIC_OP_WAKE}, 8, 0, 0, rx);
        wake_len(n);
      end
    end
  endtask : t_prechg

  // loads continuous read mode, then sends the reset pattern
  task automatic crst(input logic dual, input logic [31:0] tx, input int nbits,
                      input logic exp);
    logic [31:0] rx;
    io_mode_dual = dual;
    mode_value = 2'h2;
    mode_load = 1'b1;
    wait_clk(1);
    mode_load = 1'b0;
    chk(32'({continuous_read_flag_hi, continuous_read_flag_lo}), 32'h2, "mode loaded");
    host.frame(tx, nbits, 0, 8, rx);
    chk(32'(continuous_read_flag_lo), 32'(exp), "mode reset");
  endtask : crst

  task automatic t_crst;
    crst(1'b0, 32'hff, 8, 1'b1);
    crst(1'b0, 32'hfe, 8, 1'b0);
    crst(1'b1, 32'hff, 8, 1'b0);
    crst(1'b1, 32'hffff, 16, 1'b1);
  endtask : t_crst

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    wait_clk(5);
    srst = 1'b0;
    wait_clk(4);
    t_reset();
    t_idread();
    t_busy();
    t_wake_awake();
    t_deep();
    t_prechg();
    t_crst();
    wrap_up();
  end

  // a hang ends the run as a mismatch
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
endmodule : tb_top
